/* File: hw/ase_pkg.sv */
// Purpose: Shared constants and types of the stack command executor.
// Assumes: Eight 16-bit stack entries, entry 0 is the top.
// Notes:   Command timing is counted in core_clk cycles.
//
// Summary of operation
// - Natural log command is opcode 0x09, with bit 7 requesting service.
// - Natural log takes 4298 cycles for positive input, 20 otherwise.
// - Natural log replaces the 32-bit top; second entry kept.
// - Natural log of zero or negative input reports error code 0100.
// - Idle command keeps the stack, clears status, sets or clears service.
// - Both long rotates move the 32-bit stack up, top to bottom.
// - Long rotate 0x98/0x18 executes in 12 cycles.
// - Short rotate moves the 16-bit stack up, top to bottom.
// - Long duplicate pushes a copy of the 32-bit top in 20 cycles.
// - Short duplicate pushes a copy of the 16-bit top in 16 cycles.
// - Push pi pushes the 32-bit stack down and loads pi on top.
// - Power raises second entry to top, pops, takes 8290 cycles.
// - Power with zero or negative base reports error code 0100.
// - Power with exponent product outside plus or minus 32 reports 1100.
// - Short add sums top and second, pops, takes 16 to 18 cycles.
// - Carry out of the short add sets the carry status bit.
// - Short add overflow flags error and returns the low 16 bits.
// - Short divide gives the integer quotient of second by top, pops.
// - Short divide by zero returns the dividend and reports the error.

package ase_pkg;

  localparam int unsigned STK_DEPTH = 8;

  // Register port offsets
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_FLAG = 2'h2;

  // Opcodes, bits 6..0 of a command byte
  localparam logic [6:0] OP_LN       = 7'h09;
  localparam logic [6:0] OP_IDLE     = 7'h00;
  localparam logic [6:0] OP_ROT_D    = 7'h38;
  localparam logic [6:0] OP_ROT_F    = 7'h18;
  localparam logic [6:0] OP_ROT_S    = 7'h78;
  localparam logic [6:0] OP_DUP_D    = 7'h37;
  localparam logic [6:0] OP_DUP_F    = 7'h17;
  localparam logic [6:0] OP_DUP_S    = 7'h77;
  localparam logic [6:0] OP_PUSH_PI  = 7'h1a;
  localparam logic [6:0] OP_PWR      = 7'h0b;
  localparam logic [6:0] OP_ADD16    = 7'h6c;
  localparam logic [6:0] OP_DIV16    = 7'h6f;

  // Execution times in cycles
  localparam int unsigned CYC_LN        = 4298;
  localparam int unsigned CYC_PWR       = 8290;
  localparam int unsigned CYC_LN_BAD    = 20;
  localparam int unsigned CYC_ROT_LONG  = 12;
  localparam int unsigned CYC_ROT_SHORT = 18;
  localparam int unsigned CYC_DUP_LONG  = 20;
  localparam int unsigned CYC_DUP_SHORT = 16;
  localparam int unsigned CYC_PUSH_PI   = 16;
  localparam int unsigned CYC_ADD       = 16;
  localparam int unsigned CYC_ADD_CARRY = 18;
  localparam int unsigned CYC_DIV       = 90;
  localparam int unsigned CYC_IDLE      = 4;

  // Error field codes
  localparam logic [3:0] ERR_NONE   = 4'h0;
  localparam logic [3:0] ERR_OVF    = 4'h2;
  localparam logic [3:0] ERR_DOMAIN = 4'h4;
  localparam logic [3:0] ERR_DIV0   = 4'h8;
  localparam logic [3:0] ERR_RANGE  = 4'hc;

  // Numeric constants
  localparam logic [31:0]        PI_FLOAT    = 32'h02c90fdb;
  localparam logic [16:0]        LN2_Q16     = 17'h0b172;
  localparam logic [17:0]        LOG2E_Q16   = 18'h17154;
  localparam logic signed [63:0] EXP_LIM_Q32 = 64'sh0000_0020_0000_0000;

  typedef struct packed {
    logic       sign;
    logic       zero;
    logic       rsv;
    logic [3:0] err;
    logic       carry;
  } ase_status_s;

  typedef struct packed {
    logic       svc;
    logic [6:0] op;
  } ase_cmd_s;

  typedef struct packed {
    logic [15:0] res;
    logic        carry;
    logic        ovf;
    logic        div0;
  } ase_alu_s;

endpackage : ase_pkg

/* File: hw/ase_cycle_timer.sv */
// Purpose: Counts the execution time of one command.
// Assumes: Load only while idle; count is at least one.
// Notes:   done is high in the last cycle of the count.
`timescale 1ns/1ps
`default_nettype none

module ase_cycle_timer
  import ase_pkg::*;
#(
  parameter int unsigned CNT_W = 14
)(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] cycles,
  // Status
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cnt <= '0;
    else if (clk_en)
    begin
      if (load)
        cnt <= cycles;
      else if (cnt != '0)
        cnt <= cnt - 1'b1;
    end
  end

  assign busy = (cnt != '0);
  assign done = (cnt == CNT_W'(1));

endmodule : ase_cycle_timer

`default_nettype wire

/* File: hw/ase_short_alu.sv */
// Purpose: 16-bit two's complement add and divide.
// Assumes: Operand a is the stack top, b the second entry.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none

module ase_short_alu
  import ase_pkg::*;
(
  // Operands
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic        div_sel,
  // Result
  output ase_alu_s         out
);

  logic [16:0]        sum;
  logic signed [15:0] quo;

  assign sum = {1'b0, b} + {1'b0, a};

  always_comb
  begin
    quo = '0;
    out = '0;
    if (div_sel)
    begin
      if (a == '0)
      begin
        out.res  = b;
        out.div0 = 1'b1;
      end
      else
      begin
        quo     = $signed(b) / $signed(a);
        out.res = quo;
        // Only the most negative dividend over minus one overflows
        out.ovf = (b == 16'h8000) && (a == 16'hffff);
      end
    end
    else
    begin
      out.res   = sum[15:0];
      out.carry = sum[16];
      out.ovf   = (a[15] == b[15]) && (sum[15] != b[15]);
    end
  end

endmodule : ase_short_alu

`default_nettype wire

/* File: hw/ase_stack_exec.sv */
// Purpose: Executes stack, logarithm, power and short integer commands.
// Assumes: Host waits for busy low before issuing commands or data.
// Notes:   Logarithm and power use linear mantissa approximations.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ase_stack_exec
  import ase_pkg::*;
#(
  parameter int unsigned LN_CYCLES  = CYC_LN,
  parameter int unsigned PWR_CYCLES = CYC_PWR,
  parameter int unsigned CNT_W      = 14
)(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Device state
  output logic             busy,
  output logic             svc_req
);

  if (LN_CYCLES < 1 || PWR_CYCLES < 1 || LN_CYCLES >= (1 << CNT_W)
      || PWR_CYCLES >= (1 << CNT_W) || CNT_W > 16)
  begin : g_bad_param
    $error("ase_stack_exec: cycle counts do not fit the timer");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } ase_state_e;

  ase_state_e       state;
  ase_state_e       next_state;
  ase_cmd_s         cur_cmd;
  ase_status_s      stat;
  ase_status_s      next_stat;
  ase_alu_s         alu_out;
  logic [15:0]      stk [STK_DEPTH];
  logic [15:0]      next_stk [STK_DEPTH];
  logic [31:0]      top32;
  logic [31:0]      sec32;
  logic [31:0]      res32;
  logic [CNT_W-1:0] load_cycles;
  logic             cmd_take;
  logic             data_push;
  logic             data_pop;
  logic             tmr_busy;
  logic             apply;
  logic             ln_bad;
  logic             pwr_bad;
  logic             pwr_range;
  logic signed [31:0] ln_top;
  logic signed [31:0] ln_sec;
  logic signed [63:0] pwr_prod;

  assign top32 = {stk[0], stk[1]};
  assign sec32 = {stk[2], stk[3]};

  function automatic logic non_positive(input logic [31:0] f);
    return f[31] || (f == '0);
  endfunction : non_positive

  // Base-e logarithm in Q16.16, log2 of mantissa taken as linear
  function automatic logic signed [31:0] ln_q16(input logic [31:0] f);
    logic [7:0]         em1;
    logic signed [31:0] l2;
    logic signed [49:0] pr;
    em1 = {f[30], f[30:24]} - 8'h01;
    l2  = {{8{em1[7]}}, em1, f[22:7]};
    pr  = l2 * $signed({1'b0, LN2_Q16});
    return pr[47:16];
  endfunction : ln_q16

  // Float to Q16.16; magnitudes beyond range saturate
  function automatic logic signed [31:0] float_to_q16(input logic [31:0] f);
    logic signed [7:0] e;
    logic [63:0]       w;
    logic [31:0]       m;
    int                sh;
    e  = {f[30], f[30:24]};
    w  = {f[23:0], 40'h0};
    sh = 48 - int'(e);
    if (e > 8'sd15)
      m = 32'h7fff_ffff;
    else if (sh >= 64)
      m = '0;
    else
      m = w[31:0] >> 0 | 32'(w >> sh);
    return f[31] ? -m : m;
  endfunction : float_to_q16

  // Q16.16 to normalised float
  function automatic logic [31:0] q16_to_float(input logic signed [31:0] q);
    logic [31:0] mag;
    logic [31:0] norm;
    logic [7:0]  ex;
    int          p;
    mag = q[31] ? 32'(-q) : 32'(q);
    p   = 0;
    for (int i = 0; i < 32; i++)
      if (mag[i])
        p = i;
    norm = mag << (31 - p);
    ex   = 8'(p - 15);
    return (mag == '0) ? 32'h0 : {q[31], ex[6:0], norm[31:8]};
  endfunction : q16_to_float

  // Exponential of a Q16.16 argument already checked to lie within 32
  function automatic logic [31:0] exp_float(input logic signed [31:0] t);
    logic signed [50:0] pr;
    logic [31:0]        u;
    logic [6:0]         ex;
    pr = t * $signed({1'b0, LOG2E_Q16});
    u  = pr[47:16];
    ex = 7'(u[22:16] + 7'h01);
    return {1'b0, ex, 1'b1, u[15:0], 7'h0};
  endfunction : exp_float

  function automatic ase_status_s set_sz32(input ase_status_s s,
                                           input logic [31:0] v);
    ase_status_s r;
    r      = s;
    r.sign = v[31];
    r.zero = (v == '0);
    return r;
  endfunction : set_sz32

  function automatic ase_status_s set_sz16(input ase_status_s s,
                                           input logic [15:0] v);
    ase_status_s r;
    r      = s;
    r.sign = v[15];
    r.zero = (v == '0);
    return r;
  endfunction : set_sz16

  function automatic logic [CNT_W-1:0] cmd_cycles(input logic [6:0] op,
                                                  input logic [31:0] a);
    int unsigned n;
    case (op)
      OP_LN:                n = non_positive(a) ? CYC_LN_BAD : LN_CYCLES;
      OP_ROT_D, OP_ROT_F:   n = CYC_ROT_LONG;
      OP_ROT_S:             n = CYC_ROT_SHORT;
      OP_DUP_D, OP_DUP_F:   n = CYC_DUP_LONG;
      OP_DUP_S:             n = CYC_DUP_SHORT;
      OP_PUSH_PI:           n = CYC_PUSH_PI;
      OP_PWR:               n = PWR_CYCLES;
      OP_ADD16:             n = ({1'b0, a[31:16]} + {1'b0, a[15:0]} > 17'hffff)
                                ? CYC_ADD_CARRY : CYC_ADD;
      OP_DIV16:             n = CYC_DIV;
      default:              n = CYC_IDLE;
    endcase
    return CNT_W'(n);
  endfunction : cmd_cycles

  assign cmd_take  = reg_wr && (reg_addr == ADDR_CTRL) && (state == ST_IDLE);
  assign data_push = reg_wr && (reg_addr == ADDR_DATA) && (state == ST_IDLE);
  assign data_pop  = reg_rd && (reg_addr == ADDR_DATA) && (state == ST_IDLE);
  assign load_cycles = cmd_cycles(reg_wdata[6:0], top32);
  assign busy      = tmr_busy;

  ase_cycle_timer #(
    .CNT_W    (CNT_W)
  ) u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .load     (cmd_take),
    .cycles   (load_cycles),
    .busy     (tmr_busy),
    .done     (apply)
  );

  ase_short_alu u_alu (
    .a        (stk[0]),
    .b        (stk[1]),
    .div_sel  (cur_cmd.op == OP_DIV16),
    .out      (alu_out)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cmd_take)
          next_state = ST_EXEC;
      ST_EXEC:
        if (apply)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state <= ST_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cur_cmd <= '0;
    else if (clk_en && cmd_take)
      cur_cmd <= reg_wdata[7:0];
  end

  // Arithmetic feeding the transcendental commands
  assign ln_top    = ln_q16(top32);
  assign ln_sec    = ln_q16(sec32);
  assign ln_bad    = non_positive(top32);
  assign pwr_bad   = non_positive(sec32);
  assign pwr_prod  = float_to_q16(top32) * ln_sec;
  assign pwr_range = (pwr_prod > EXP_LIM_Q32) || (pwr_prod < -EXP_LIM_Q32);

  // Result of the command in flight, applied on the last cycle
  always_comb
  begin
    next_stk  = stk;
    next_stat = stat;
    res32     = top32;
    case (cur_cmd.op)
      OP_LN:
      begin
        if (ln_bad)
          next_stat.err = ERR_DOMAIN;
        else
        begin
          res32         = q16_to_float(ln_top);
          next_stat.err = ERR_NONE;
        end
        next_stk[0] = res32[31:16];
        next_stk[1] = res32[15:0];
        next_stat   = set_sz32(next_stat, res32);
      end
      OP_IDLE:
        next_stat = '0;
      OP_ROT_D, OP_ROT_F:
      begin
        for (int i = 0; i < STK_DEPTH; i++)
          next_stk[i] = stk[(i + 2) % STK_DEPTH];
        next_stat = set_sz32(stat, sec32);
      end
      OP_ROT_S:
      begin
        for (int i = 0; i < STK_DEPTH; i++)
          next_stk[i] = stk[(i + 1) % STK_DEPTH];
        next_stat = set_sz16(stat, stk[1]);
      end
      OP_DUP_D, OP_DUP_F:
      begin
        for (int i = 2; i < STK_DEPTH; i++)
          next_stk[i] = stk[i - 2];
        next_stat = set_sz32(stat, top32);
      end
      OP_DUP_S:
      begin
        for (int i = 1; i < STK_DEPTH; i++)
          next_stk[i] = stk[i - 1];
        next_stat = set_sz16(stat, stk[0]);
      end
      OP_PUSH_PI:
      begin
        for (int i = 2; i < STK_DEPTH; i++)
          next_stk[i] = stk[i - 2];
        next_stk[0] = PI_FLOAT[31:16];
        next_stk[1] = PI_FLOAT[15:0];
        next_stat   = set_sz32(stat, PI_FLOAT);
      end
      OP_PWR:
      begin
        res32 = sec32;
        if (pwr_bad)
          next_stat.err = ERR_DOMAIN;
        else if (pwr_range)
          next_stat.err = ERR_RANGE;
        else
        begin
          res32         = exp_float(pwr_prod[47:16]);
          next_stat.err = ERR_NONE;
        end
        next_stk[0] = res32[31:16];
        next_stk[1] = res32[15:0];
        for (int i = 2; i < STK_DEPTH - 2; i++)
          next_stk[i] = stk[i + 2];
        next_stat = set_sz32(next_stat, res32);
      end
      OP_ADD16, OP_DIV16:
      begin
        next_stk[0] = alu_out.res;
        for (int i = 1; i < STK_DEPTH - 1; i++)
          next_stk[i] = stk[i + 1];
        next_stat = set_sz16(stat, alu_out.res);
        if (cur_cmd.op == OP_ADD16)
          next_stat.carry = alu_out.carry;
        if (alu_out.div0)
          next_stat.err = ERR_DIV0;
        else if (alu_out.ovf)
          next_stat.err = ERR_OVF;
        else
          next_stat.err = ERR_NONE;
      end
      default:
        next_stat = stat;
    endcase
  end

  // Pushes and pops only happen while idle, so they never meet apply
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < STK_DEPTH; i++)
        stk[i] <= '0;
    end
    else if (clk_en)
    begin
      if (apply)
        stk <= next_stk;
      else if (data_push)
      begin
        for (int i = 1; i < STK_DEPTH; i++)
          stk[i] <= stk[i - 1];
        stk[0] <= reg_wdata;
      end
      else if (data_pop)
      begin
        for (int i = 0; i < STK_DEPTH; i++)
          stk[i] <= stk[(i + 1) % STK_DEPTH];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      stat <= '0;
    else if (clk_en && apply)
      stat <= next_stat;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      svc_req <= 1'b0;
    else if (clk_en)
    begin
      if (apply)
        svc_req <= cur_cmd.svc;
      else if (cmd_take)
        svc_req <= 1'b0;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reg_rdata <= '0;
    else if (clk_en)
    begin
      if (!reg_rd)
        reg_rdata <= '0;
      else if (reg_addr == ADDR_DATA)
        reg_rdata <= stk[0];
      else if (reg_addr == ADDR_CTRL)
        reg_rdata <= {8'h00, stat};
      else if (reg_addr == ADDR_FLAG)
        reg_rdata <= {14'h0000, svc_req, tmr_busy};
      else
        reg_rdata <= '0;
    end
  end

endmodule : ase_stack_exec

`default_nettype wire

/* File: tb/ase_stack_exec_props.sv */
// Purpose: Port-level timing and service checks of the executor.
// Assumes: clk_en stays high while a command runs.
// Notes:   Bound into ase_stack_exec below.
`timescale 1ns/1ps
`default_nettype none

module ase_stack_exec_props
  import ase_pkg::*;
#(
  parameter int unsigned LN_CYCLES  = CYC_LN,
  parameter int unsigned PWR_CYCLES = CYC_PWR,
  parameter int unsigned CNT_W      = 14
)(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  // Register port
  input wire logic [1:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Device state
  input wire logic        busy,
  input wire logic        svc_req
);
  logic       acc;
  logic [6:0] op_q;
  logic       svc_q;
  int         cnt;

  assign acc = clk_en && reg_wr && (reg_addr == ADDR_CTRL) && !busy;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      op_q  <= OP_IDLE;
      svc_q <= 1'b0;
    end
    else if (acc)
    begin
      op_q  <= reg_wdata[6:0];
      svc_q <= reg_wdata[7];
    end
  end

  // Busy cycles of the command in flight
  always_ff @(posedge core_clk)
  begin
    if (!nrst || acc)
      cnt <= 0;
    else if (busy && clk_en)
      cnt <= cnt + 1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_BUSY_START: assert property (acc |=> busy)
    else $error("busy not raised after command");
  AST_SVC_CLEAR: assert property (acc |=> !svc_req)
    else $error("service request not cleared at command");
  AST_SVC_DONE: assert property ($fell(busy) |-> svc_req == svc_q)
    else $error("service request differs from command bit 7");
  AST_ROT_LONG_TIME: assert property ($fell(busy) && op_q == OP_ROT_F |-> cnt == 12)
    else $error("long rotate time wrong");
  AST_DUP_LONG_TIME: assert property ($fell(busy) && op_q == OP_DUP_D |-> cnt == 20)
    else $error("long duplicate time wrong");
  AST_DUP_SHORT_TIME: assert property ($fell(busy) && op_q == OP_DUP_S |-> cnt == 16)
    else $error("short duplicate time wrong");
  AST_ADD_TIME: assert property ($fell(busy) && op_q == OP_ADD16 |-> cnt inside {16, 18})
    else $error("short add time wrong");
  AST_LN_TIME: assert property ($fell(busy) && op_q == OP_LN |-> cnt == 20 || cnt == LN_CYCLES)
    else $error("log time wrong");
  AST_PWR_TIME: assert property ($fell(busy) && op_q == OP_PWR |-> cnt == PWR_CYCLES)
    else $error("power time wrong");

  COV_ADD: cover property (acc && reg_wdata[6:0] == OP_ADD16);
  COV_LN: cover property (acc && reg_wdata[6:0] == OP_LN);
  COV_SVC: cover property ($rose(svc_req));
endmodule : ase_stack_exec_props

bind ase_stack_exec ase_stack_exec_props #(
  .LN_CYCLES(LN_CYCLES), .PWR_CYCLES(PWR_CYCLES), .CNT_W(CNT_W)
) u_props (
  .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .busy(busy), .svc_req(svc_req)
);
`default_nettype wire

/* File: tb/ase_host_model.sv */
// Purpose: Host processor issuing data and commands on the register port.
// Assumes: Signals change by NBA right after a rising edge.
// Notes:   Waits on busy before the next request.
`timescale 1ns/1ps
`default_nettype none

module ase_host_model
  import ase_pkg::*;
(
  // Clock and device state
  input  wire logic        core_clk,
  input  wire logic        busy,
  input  wire logic [15:0] reg_rdata,
  // Register port
  output var logic  [1:0]  reg_addr,
  output var logic  [15:0] reg_wdata,
  output var logic         reg_wr,
  output var logic         reg_rd
);
  initial
  begin
    reg_addr  = 2'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic cmd(input logic [7:0] c);
    wr(ADDR_CTRL, {8'h00, c});
    @(posedge core_clk);
    #1;
    // A hang is left to the bench timeout, never passed over silently
    while (busy)
      @(posedge core_clk) #1;
  endtask : cmd
endmodule : ase_host_model
`default_nettype wire

/* File: tb/ase_stack_exec_tb.sv */
// Purpose: Self-checking bench of the stack command executor.
// Assumes: Shortened log and power times via parameters.
// Notes:   Stack model tracks only the test groups up to the freeze test.
`timescale 1ns/1ps
`default_nettype none

module ase_stack_exec_tb
  import ase_pkg::*;
;
  logic        core_clk, nrst, clk_en, reg_wr, reg_rd, busy, svc_req;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [15:0] m [8];
  logic [7:0]  ops [8] = '{8'h78, 8'h98, 8'h38, 8'hf7, 8'hb7, 8'h17, 8'h9a, 8'h18};
  int          n_fail, n_tests, cyc;

  ase_stack_exec #(.LN_CYCLES(40), .PWR_CYCLES(60)) dut (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy), .svc_req(svc_req));
  ase_host_model host (
    .core_clk(core_clk), .busy(busy), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Cuts a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      $display("mismatch timeout expected end got hang");
      end_sim;
    end
  end

  task automatic rchk(input string nm, input logic [1:0] a, input logic [15:0] e,
                      input logic [15:0] mk = 16'hffff);
    logic [15:0] v;
    host.rd(a, v);
    n_tests++;
    if ((v & mk) !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h got %h", nm, e, v & mk);
    end
  endtask : rchk

  task automatic mpush(input logic [15:0] v);
    for (int i = 7; i > 0; i--)
      m[i] = m[i-1];
    m[0] = v;
  endtask : mpush

  task automatic push(input logic [15:0] v);
    host.wr(ADDR_DATA, v);
    mpush(v);
  endtask : push

  task automatic mrot;
    logic [15:0] t;
    t = m[0];
    for (int i = 0; i < 7; i++)
      m[i] = m[i+1];
    m[7] = t;
  endtask : mrot

  // Reading all eight entries rotates the stack back to where it was
  task automatic stk_check;
    for (int i = 0; i < 8; i++)
      rchk("stack", ADDR_DATA, m[i]);
  endtask : stk_check

  task automatic apply(input logic [7:0] c);
    logic [15:0] a, b;
    a = m[0];
    b = m[1];
    host.cmd(c);
    case (c[6:0])
      OP_ROT_S: mrot;
      OP_ROT_F, OP_ROT_D:
      begin
        mrot;
        mrot;
      end
      OP_DUP_S: mpush(a);
      OP_DUP_F, OP_DUP_D:
      begin
        mpush(b);
        mpush(a);
      end
      default:
      begin
        mpush(PI_FLOAT[15:0]);
        mpush(PI_FLOAT[31:16]);
      end
    endcase
  endtask : apply

  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    m = '{default: 16'h0000};
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rchk("flags", ADDR_FLAG, 16'h0000);
    rchk("status", ADDR_CTRL, 16'h0000, 16'h00ff);
    host.wr(2'h3, 16'h1234);
    rchk("unmapped", 2'h3, 16'h0000);
    stk_check;
    $display("test reset done");
    for (int i = 1; i <= 8; i++)
      push(16'(i));
    for (int i = 0; i < 8; i++)
    begin
      apply(ops[i]);
      stk_check;
    end
    $display("test stack moves done");
    host.cmd(8'h80);
    rchk("svc set", ADDR_FLAG, 16'h0002);
    rchk("idle status", ADDR_CTRL, 16'h0000, 16'h00ff);
    host.cmd(8'h00);
    rchk("svc clear", ADDR_FLAG, 16'h0000);
    $display("test idle done");
    // Writes and command progress must be frozen while clk_en is low
    clk_en <= 1'b0;
    host.wr(ADDR_DATA, 16'h5a5a);
    clk_en <= 1'b1;
    rchk("frozen push", ADDR_DATA, m[0]);
    host.wr(ADDR_CTRL, 16'h0080);
    clk_en <= 1'b0;
    repeat (10) @(posedge core_clk);
    clk_en <= 1'b1;
    rchk("frozen busy", ADDR_FLAG, 16'h0001);
    repeat (6) @(posedge core_clk);
    rchk("thawed svc", ADDR_FLAG, 16'h0002);
    $display("test freeze done");
    push(16'h7fff);
    push(16'h0001);
    host.cmd(8'h6c);
    rchk("ovf status", ADDR_CTRL, 16'h0084, 16'h00ff);
    rchk("ovf sum", ADDR_DATA, 16'h8000);
    push(16'hffff);
    push(16'h0001);
    host.cmd(8'hec);
    rchk("carry status", ADDR_CTRL, 16'h0041, 16'h00ff);
    rchk("carry sum", ADDR_DATA, 16'h0000);
    $display("test add done");
    host.cmd(8'h00);
    push(16'h0007);
    push(16'h0000);
    host.cmd(8'h6f);
    rchk("div0 status", ADDR_CTRL, 16'h0010, 16'h00ff);
    rchk("div0 result", ADDR_DATA, 16'h0007);
    push(16'hff9c);
    push(16'h0007);
    host.cmd(8'h6f);
    rchk("div status", ADDR_CTRL, 16'h0080, 16'h00ff);
    rchk("quotient", ADDR_DATA, 16'hfff2);
    $display("test divide done");
    push(16'h0000);
    push(16'h0000);
    host.cmd(8'h89);
    rchk("ln zero status", ADDR_CTRL, 16'h0048, 16'h00ff);
    push(16'h0000);
    push(16'h0180);
    host.cmd(8'h09);
    rchk("ln error", ADDR_CTRL, 16'h0000, 16'h001e);
    $display("test log done");
    push(16'h0000);
    push(16'h8180);
    push(16'h0000);
    push(16'h0180);
    host.cmd(8'h0b);
    rchk("pwr domain", ADDR_CTRL, 16'h0008, 16'h001e);
    push(16'h0000);
    push(16'h0280);
    push(16'h0000);
    push(16'h0780);
    host.cmd(8'h8b);
    rchk("pwr range", ADDR_CTRL, 16'h0018, 16'h001e);
    $display("test power done");
    // Mid-run reset must clear service request, status and stack
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rchk("reset flags", ADDR_FLAG, 16'h0000);
    rchk("reset status", ADDR_CTRL, 16'h0000, 16'h00ff);
    rchk("reset top", ADDR_DATA, 16'h0000);
    $display("test mid reset done");
    end_sim;
  end
endmodule : ase_stack_exec_tb
`default_nettype wire
